/* File: core/crsf_alu.sv */
// Purpose: Result and result-flag computation for byte and word operations
// Assumes: Operands arrive zero-extended in the low byte for byte operations
// Notes:   Purely combinational; the caller stores result and flags
`timescale 1ns/10ps
module crsf_alu (
  // Operation
  input  wire crsf_pkg::crsf_alu_op_t alu_op,
  input  wire logic                   word,
  input  wire logic                   cin,
  // Operands
  input  wire logic [15:0]            a,
  input  wire logic [15:0]            b,
  // Result
  output crsf_pkg::crsf_result_t      out
);
  import crsf_pkg::*;

  logic [16:0] s;
  logic [15:0] x;
  logic [15:0] y;
  logic        sub;
  logic        arith;
  logic        msb_r;
  logic        msb_x;
  logic        msb_y;
  logic [15:0] r;

  // Operand selection and sum
  always_comb begin
    x     = a;
    y     = b;
    sub   = 1'b0;
    arith = 1'b1;
    r     = 16'h0000;
    s     = 17'h00000;
    unique case (alu_op)
      ALU_ADD:  s = {1'b0, a} + {1'b0, b};
      ALU_ADC:  s = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
      ALU_SUB,
      ALU_CMP:  begin s = {1'b0, a} - {1'b0, b}; sub = 1'b1; end
      ALU_SBB:  begin s = {1'b0, a} - {1'b0, b} - {16'h0000, cin}; sub = 1'b1; end
      ALU_INC:  begin y = 16'h0001; s = {1'b0, a} + 17'h00001; end
      ALU_DEC:  begin y = 16'h0001; s = {1'b0, a} - 17'h00001; sub = 1'b1; end
      ALU_NEG:  begin x = 16'h0000; y = a; s = 17'h00000 - {1'b0, a}; sub = 1'b1; end
      ALU_AND,
      ALU_TEST: begin arith = 1'b0; r = a & b; end
      ALU_OR:   begin arith = 1'b0; r = a | b; end
      ALU_XOR:  begin arith = 1'b0; r = a ^ b; end
      ALU_NOT:  begin arith = 1'b0; r = ~a; end
      ALU_MOV:  begin arith = 1'b0; r = b; end
      default:  ;
    endcase
    if (arith) r = s[15:0];
    if (!word) r = {8'h00, r[7:0]};
  end

  // Sign bits at the destination width
  assign msb_r = word ? r[15] : r[7];
  assign msb_x = word ? x[15] : x[7];
  assign msb_y = word ? y[15] : y[7];

  // Flags and update mask
  always_comb begin
    out.res   = r;
    out.flags = 16'h0000;
    out.write = !(alu_op inside {ALU_CMP, ALU_TEST});
    out.flags[FL_CARRY]  = arith & (word ? s[16] : s[8]);
    out.flags[FL_PARITY] = crsf_par_even(r[7:0]);
    out.flags[FL_AUX]    = arith & (x[4] ^ y[4] ^ r[4]);
    out.flags[FL_ZERO]   = (r == 16'h0000);
    out.flags[FL_SIGN]   = msb_r;
    out.flags[FL_OVF]    = arith & (sub ? (msb_x != msb_y) & (msb_r != msb_x)
                                        : (msb_x == msb_y) & (msb_r != msb_x));
    if (alu_op inside {ALU_INC, ALU_DEC}) out.mask = INCDEC_MASK;
    else if (alu_op inside {ALU_MOV, ALU_NOT}) out.mask = 16'h0000;
    else out.mask = ARITH_MASK;
  end

endmodule : crsf_alu

/* File: core/crsf_core.sv */
// Purpose: General, segment, pointer, machine status and flag registers of the core
// Assumes: Requests come from same-clock sequencing logic; the interrupt pin is asynchronous
// Notes:   Every register is a plain flip-flop that holds without any refresh
`timescale 1ns/10ps
module crsf_core (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Operation and flag commands
  input  wire crsf_pkg::crsf_op_t       op_i,
  input  wire crsf_pkg::crsf_flag_cmd_t flag_cmd_i,
  input  wire logic [15:0]              flag_load_i,
  // Offset and address generation
  input  wire crsf_pkg::crsf_ea_t       ea_i,
  input  wire logic [23:0]              seg_base_i,
  // Register access
  input  wire logic [2:0]               rd_idx_i,
  input  wire logic                     rd_word_i,
  input  wire logic                     rd_hi_i,
  input  wire logic                     seg_wr_i,
  input  wire logic [1:0]               seg_idx_i,
  input  wire logic [15:0]              seg_data_i,
  input  wire logic                     msw_wr_i,
  input  wire logic [15:0]              msw_data_i,
  // Sequencing
  input  wire logic [3:0]               ip_adv_i,
  input  wire logic                     ip_load_i,
  input  wire logic [15:0]              ip_data_i,
  input  wire logic                     insn_done_i,
  input  wire logic                     str_step_i,
  input  wire logic                     str_word_i,
  input  wire logic                     intr_req_i,
  // Register views
  output logic [15:0]                   rd_data_q,
  output logic [15:0]                   flags_q,
  output logic [15:0]                   msw_q,
  output logic [15:0]                   ip_q,
  // Memory side
  output logic [15:0]                   ea_off_q,
  output logic [23:0]                   phys_addr_q,
  output logic                          addr_valid_q,
  output logic                          mem_wr_q,
  output logic [15:0]                   mem_wdata_q,
  // Interrupt decisions and errors
  output logic                          trap_take_q,
  output logic                          intr_take_q,
  output logic                          op_bad_q
);
  import crsf_pkg::*;

  logic [15:0]  gpr_q [8];
  logic [15:0]  seg_q [4];
  logic         intr_meta_q;
  logic         intr_sync_q;
  logic [15:0]  opa;
  logic [15:0]  opb;
  logic         op_bad;
  logic         op_go;
  crsf_result_t alu_out;
  logic [15:0]  str_inc;
  logic [15:0]  ea_off_d;
  logic [1:0]   seg_sel;
  logic         take_trap;
  logic         take_intr;
  logic [15:0]  flags_d;

  // Read one operand from register, instruction stream or memory
  function automatic logic [15:0] fetch(input logic [15:0] r, input logic word, input logic hi);
    return word ? r : (hi ? {8'h00, r[15:8]} : {8'h00, r[7:0]});
  endfunction : fetch

  // Byte half splice into a word register
  function automatic logic [15:0] merge(input logic [15:0] cur, input logic [15:0] v,
                                        input logic word, input logic hi);
    return word ? v : (hi ? {v[7:0], cur[7:0]} : {cur[15:8], v[7:0]});
  endfunction : merge

  // High byte halves exist only for the first four registers
  assign op_bad = op_i.valid & ((op_i.nops == 2'd3) |
                  (!op_i.word & op_i.dst == DST_REG & op_i.dst_hi & op_i.dst_idx[2]) |
                  (!op_i.word & op_i.src == SRC_REG & op_i.src_hi & op_i.src_idx[2]));
  assign op_go  = op_i.valid & !op_bad & (op_i.nops != 2'd0);

  // Operand selection for all six two-operand combinations
  always_comb begin
    opa = (op_i.dst == DST_REG) ? fetch(gpr_q[op_i.dst_idx], op_i.word, op_i.dst_hi)
                                : fetch(op_i.mem_dst, op_i.word, 1'b0);
    unique case (op_i.src)
      SRC_REG: opb = fetch(gpr_q[op_i.src_idx], op_i.word, op_i.src_hi);
      SRC_IMM: opb = fetch(op_i.imm, op_i.word, 1'b0);
      SRC_MEM: opb = fetch(op_i.mem_src, op_i.word, 1'b0);
      default: opb = 16'h0000;
    endcase
    if (op_i.nops != 2'd2) opb = 16'h0000;
  end

  crsf_alu u_alu (
    .alu_op (op_i.alu_op),
    .word   (op_i.word),
    .cin    (flags_q[FL_CARRY]),
    .a      (opa),
    .b      (opb),
    .out    (alu_out)
  );

  // Interrupt pin synchroniser
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      intr_meta_q <= 1'b0;
      intr_sync_q <= 1'b0;
    end else begin
      intr_meta_q <= intr_req_i;
      intr_sync_q <= intr_meta_q;
    end
  end

  // String index step by element size; direction is applied at the index update
  assign str_inc = str_word_i ? 16'h0002 : 16'h0001;

  // General registers, held as static flops between any two clocks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) gpr_q[i] <= GPR_RST;
    end else begin
      if (str_step_i) begin
        gpr_q[R_SRCI] <= flags_q[FL_DIR] ? gpr_q[R_SRCI] - str_inc : gpr_q[R_SRCI] + str_inc;
        gpr_q[R_DSTI] <= flags_q[FL_DIR] ? gpr_q[R_DSTI] - str_inc : gpr_q[R_DSTI] + str_inc;
      end
      if (op_go && alu_out.write && op_i.dst == DST_REG)
        gpr_q[op_i.dst_idx] <= merge(gpr_q[op_i.dst_idx], alu_out.res, op_i.word, op_i.dst_hi);
    end
  end

  // Memory destination write-back
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_wr_q    <= 1'b0;
      mem_wdata_q <= 16'h0000;
      op_bad_q    <= 1'b0;
    end else begin
      mem_wr_q    <= op_go & alu_out.write & (op_i.dst == DST_MEM);
      mem_wdata_q <= alu_out.res;
      op_bad_q    <= op_bad;
    end
  end

  // Segment, pointer and machine status registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) seg_q[i] <= SEG_RST;
      ip_q  <= IP_RST;
      msw_q <= MSW_RST;
    end else begin
      if (seg_wr_i) seg_q[seg_idx_i] <= seg_data_i;
      if (ip_load_i) ip_q <= ip_data_i;
      else ip_q <= ip_q + {12'h000, ip_adv_i};
      if (msw_wr_i) msw_q <= msw_data_i;
    end
  end

  // Interrupt decisions at instruction end; trap goes before maskable
  assign take_trap = insn_done_i & flags_q[FL_TRAP];
  assign take_intr = insn_done_i & !take_trap & flags_q[FL_INTEN] & intr_sync_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trap_take_q <= 1'b0;
      intr_take_q <= 1'b0;
    end else begin
      trap_take_q <= take_trap;
      intr_take_q <= take_intr;
    end
  end

  // Flag word next value: result, then command, then interrupt entry
  always_comb begin
    flags_d = flags_q;
    if (op_go) flags_d = (flags_q & ~alu_out.mask) | (alu_out.flags & alu_out.mask);
    unique case (flag_cmd_i)
      FC_STC:  flags_d[FL_CARRY] = 1'b1;
      FC_CLC:  flags_d[FL_CARRY] = 1'b0;
      FC_CMC:  flags_d[FL_CARRY] = ~flags_q[FL_CARRY];
      FC_STD:  flags_d[FL_DIR]   = 1'b1;
      FC_CLD:  flags_d[FL_DIR]   = 1'b0;
      FC_STI:  flags_d[FL_INTEN] = 1'b1;
      FC_CLI:  flags_d[FL_INTEN] = 1'b0;
      FC_LOAD: flags_d = flag_load_i & FLAGS_WMASK;
      default: ;
    endcase
    if (take_trap) flags_d[FL_TRAP] = 1'b0;
    if (take_trap || take_intr) flags_d[FL_INTEN] = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) flags_q <= FLAGS_RST;
    else        flags_q <= flags_d;
  end

  // Offset sum from displacement, base and index
  always_comb begin
    logic [15:0] base;
    logic [15:0] idx;
    logic [15:0] disp;
    base = ea_i.base_bp ? gpr_q[R_BPTR] : gpr_q[R_BASE];
    idx  = ea_i.index_di ? gpr_q[R_DSTI] : gpr_q[R_SRCI];
    disp = ea_i.disp_byte ? {{8{ea_i.disp[7]}}, ea_i.disp[7:0]} : ea_i.disp;
    unique case (ea_i.mode)
      AM_DIRECT:     ea_off_d = disp;
      AM_RIND_BASE:  ea_off_d = base;
      AM_RIND_INDEX: ea_off_d = idx;
      AM_BASED:      ea_off_d = base + disp;
      AM_INDEXED:    ea_off_d = idx + disp;
      AM_BIDX:       ea_off_d = base + idx;
      AM_BIDX_DISP:  ea_off_d = base + idx + disp;
      default:       ea_off_d = 16'h0000;
    endcase
    if (ea_i.seg_ovr_en) seg_sel = ea_i.seg_ovr;
    else if (ea_i.base_bp && ea_i.mode inside {AM_RIND_BASE, AM_BASED, AM_BIDX, AM_BIDX_DISP})
      seg_sel = S_STACK;
    else seg_sel = S_DATA;
  end

  // Physical address per addressing mode of the machine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ea_off_q     <= 16'h0000;
      phys_addr_q  <= 24'h000000;
      addr_valid_q <= 1'b0;
    end else begin
      addr_valid_q <= ea_i.valid;
      ea_off_q     <= ea_off_d;
      if (msw_q[MSW_PE])
        phys_addr_q <= seg_base_i + {8'h00, ea_off_d};
      else
        phys_addr_q <= {4'h0, {seg_q[seg_sel], 4'h0} + {4'h0, ea_off_d}};
    end
  end

  // Register read view
  always_ff @(posedge clk) begin
    if (!rst_n) rd_data_q <= 16'h0000;
    else        rd_data_q <= fetch(gpr_q[rd_idx_i], rd_word_i, rd_hi_i & !rd_idx_i[2]);
  end

  // Checks
  logic reg_word_op;
  assign reg_word_op = op_go & alu_out.write & op_i.dst == DST_REG & op_i.word & flag_cmd_i == FC_NONE;

  property p_trap;
    @(posedge clk) disable iff (!rst_n)
      insn_done_i && flags_q[FL_TRAP] |=> trap_take_q && !flags_q[FL_TRAP];
  endproperty
  a_trap: assert property (p_trap) else $error("trap not taken or flag not cleared");

  property p_intr;
    @(posedge clk) disable iff (!rst_n) intr_take_q |-> $past(flags_q[FL_INTEN]) && !flags_q[FL_INTEN];
  endproperty
  a_intr: assert property (p_intr) else $error("maskable taken while disabled");

  property p_dir;
    @(posedge clk) disable iff (!rst_n)
      str_step_i && str_word_i && !op_i.valid && flags_q[FL_DIR] |=> gpr_q[R_SRCI] == $past(gpr_q[R_SRCI]) - 16'h0002;
  endproperty
  a_dir: assert property (p_dir) else $error("string index not decremented");

  property p_zero_sign_par;
    @(posedge clk) disable iff (!rst_n)
      reg_word_op && !take_trap && !str_step_i |=>
        flags_q[FL_ZERO] == (gpr_q[$past(op_i.dst_idx)] == 16'h0000) &&
        flags_q[FL_SIGN] == gpr_q[$past(op_i.dst_idx)][15] &&
        flags_q[FL_PARITY] == ~^gpr_q[$past(op_i.dst_idx)][7:0] || $past(op_i.alu_op) inside {ALU_MOV, ALU_NOT};
  endproperty
  a_zero_sign_par: assert property (p_zero_sign_par) else $error("result flags disagree with register");

  property p_carry;
    @(posedge clk) disable iff (!rst_n)
      op_go && op_i.alu_op == ALU_ADD && op_i.word && flag_cmd_i == FC_NONE |=>
        flags_q[FL_CARRY] == ((17'({1'b0, $past(opa)}) + 17'({1'b0, $past(opb)})) > 17'h0ffff);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong after word add");

  property p_byte_half;
    @(posedge clk) disable iff (!rst_n)
      op_go && alu_out.write && op_i.dst == DST_REG && !op_i.word && !op_i.dst_hi && !str_step_i |=>
        gpr_q[$past(op_i.dst_idx)][15:8] == $past(gpr_q[op_i.dst_idx][15:8]);
  endproperty
  a_byte_half: assert property (p_byte_half) else $error("byte write disturbed upper half");

  property p_real;
    @(posedge clk) disable iff (!rst_n) ea_i.valid && !msw_q[MSW_PE] |=> phys_addr_q[23:20] == 4'h0;
  endproperty
  a_real: assert property (p_real) else $error("real mode address above one megabyte");

  property p_seg;
    @(posedge clk) disable iff (!rst_n) seg_wr_i |=> seg_q[$past(seg_idx_i)] == $past(seg_data_i);
  endproperty
  a_seg: assert property (p_seg) else $error("segment register not loaded");

  property p_ip;
    @(posedge clk) disable iff (!rst_n) !ip_load_i ##1 !ip_load_i |-> ip_q == $past(ip_q) + 16'($past(ip_adv_i));
  endproperty
  a_ip: assert property (p_ip) else $error("instruction pointer advance wrong");

  c_trap:  cover property (@(posedge clk) disable iff (!rst_n) trap_take_q);
  c_intr:  cover property (@(posedge clk) disable iff (!rst_n) intr_take_q);
  c_mm:    cover property (@(posedge clk) disable iff (!rst_n) op_go && op_i.src == SRC_MEM && op_i.dst == DST_MEM);
  c_prot:  cover property (@(posedge clk) disable iff (!rst_n) ea_i.valid && msw_q[MSW_PE]);

endmodule : crsf_core

/* File: core/crsf_pkg.sv */
// Purpose: Shared constants, types and helpers of the register set and flags block
// Assumes: Single processor clock, synchronous active-low reset
// Notes:   Register indices follow the accumulator, count, data, base ordering
package crsf_pkg;

  // Flag word bit positions
  localparam int FL_CARRY  = 0;
  localparam int FL_PARITY = 2;
  localparam int FL_AUX    = 4;
  localparam int FL_ZERO   = 6;
  localparam int FL_SIGN   = 7;
  localparam int FL_TRAP   = 8;
  localparam int FL_INTEN  = 9;
  localparam int FL_DIR    = 10;
  localparam int FL_OVF    = 11;

  // Masks and reset values
  localparam logic [15:0] FLAGS_RST   = 16'h0000;
  localparam logic [15:0] FLAGS_WMASK = 16'h0fd5;
  localparam logic [15:0] ARITH_MASK  = 16'h08d5;
  localparam logic [15:0] INCDEC_MASK = 16'h08d4;
  localparam logic [15:0] GPR_RST     = 16'h0000;
  localparam logic [15:0] SEG_RST     = 16'h0000;
  localparam logic [15:0] IP_RST      = 16'h0000;
  localparam logic [15:0] MSW_RST     = 16'h0000;
  localparam int          MSW_PE      = 0;

  // General register indices
  localparam logic [2:0] R_ACC  = 3'h0;
  localparam logic [2:0] R_CNT  = 3'h1;
  localparam logic [2:0] R_DAT  = 3'h2;
  localparam logic [2:0] R_BASE = 3'h3;
  localparam logic [2:0] R_BPTR = 3'h5;
  localparam logic [2:0] R_SRCI = 3'h6;
  localparam logic [2:0] R_DSTI = 3'h7;

  // Segment register indices
  localparam logic [1:0] S_EXTRA = 2'h0;
  localparam logic [1:0] S_CODE  = 2'h1;
  localparam logic [1:0] S_STACK = 2'h2;
  localparam logic [1:0] S_DATA  = 2'h3;

  // Address widths per mode
  localparam int REAL_AW = 20;
  localparam int PROT_AW = 24;

  typedef enum logic [3:0] {
    ALU_MOV, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBB, ALU_CMP, ALU_AND,
    ALU_OR, ALU_XOR, ALU_TEST, ALU_INC, ALU_DEC, ALU_NEG, ALU_NOT
  } crsf_alu_op_t;

  typedef enum logic [1:0] {SRC_REG, SRC_IMM, SRC_MEM} crsf_src_t;
  typedef enum logic       {DST_REG, DST_MEM} crsf_dst_t;

  typedef enum logic [3:0] {
    FC_NONE, FC_STC, FC_CLC, FC_CMC, FC_STD, FC_CLD, FC_STI, FC_CLI, FC_LOAD
  } crsf_flag_cmd_t;

  typedef enum logic [2:0] {
    AM_DIRECT, AM_RIND_BASE, AM_RIND_INDEX, AM_BASED, AM_INDEXED, AM_BIDX, AM_BIDX_DISP
  } crsf_amode_t;

  // One operation request
  typedef struct packed {
    logic         valid;
    logic [1:0]   nops;
    crsf_alu_op_t alu_op;
    logic         word;
    crsf_src_t    src;
    crsf_dst_t    dst;
    logic [2:0]   src_idx;
    logic         src_hi;
    logic [2:0]   dst_idx;
    logic         dst_hi;
    logic [15:0]  imm;
    logic [15:0]  mem_src;
    logic [15:0]  mem_dst;
  } crsf_op_t;

  // One offset calculation request
  typedef struct packed {
    logic        valid;
    crsf_amode_t mode;
    logic        base_bp;
    logic        index_di;
    logic        disp_byte;
    logic [15:0] disp;
    logic        seg_ovr_en;
    logic [1:0]  seg_ovr;
  } crsf_ea_t;

  // Arithmetic result bundle
  typedef struct packed {
    logic [15:0] res;
    logic [15:0] flags;
    logic [15:0] mask;
    logic        write;
  } crsf_result_t;

  // Even count of ones in a byte
  function automatic logic crsf_par_even(input logic [7:0] b);
    return ~^b;
  endfunction : crsf_par_even

endpackage : crsf_pkg

/* File: verification/crsf_tb.sv */
// Purpose: Self-checking bench for the register set and flags core
// Assumes: Inputs change at the falling edge, results read at the next falling edge
// Notes:   Expected values worked out by hand from operands
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module testbench;
  import crsf_pkg::*;
  logic clk, rst_n, seg_wr_i, msw_wr_i, ip_load_i, insn_done_i, str_step_i, str_word_i, intr_req_i;
  logic rd_word_i, rd_hi_i, addr_valid_q, mem_wr_q, trap_take_q, intr_take_q, op_bad_q;
  crsf_op_t       op_i;
  crsf_flag_cmd_t flag_cmd_i;
  crsf_ea_t       ea_i;
  logic [15:0]    flag_load_i, seg_data_i, msw_data_i, ip_data_i, rd_data_q, flags_q, msw_q, ip_q;
  logic [15:0]    ea_off_q, mem_wdata_q;
  logic [23:0]    seg_base_i, phys_addr_q;
  logic [2:0]     rd_idx_i;
  logic [1:0]     seg_idx_i;
  logic [3:0]     ip_adv_i;
  int             mismatches, cmp_count;

  crsf_core crsf_core_inst (.clk(clk), .rst_n(rst_n), .op_i(op_i), .flag_cmd_i(flag_cmd_i),
    .flag_load_i(flag_load_i), .ea_i(ea_i), .seg_base_i(seg_base_i), .rd_idx_i(rd_idx_i),
    .rd_word_i(rd_word_i), .rd_hi_i(rd_hi_i), .seg_wr_i(seg_wr_i), .seg_idx_i(seg_idx_i),
    .seg_data_i(seg_data_i), .msw_wr_i(msw_wr_i), .msw_data_i(msw_data_i), .ip_adv_i(ip_adv_i),
    .ip_load_i(ip_load_i), .ip_data_i(ip_data_i), .insn_done_i(insn_done_i), .str_step_i(str_step_i),
    .str_word_i(str_word_i), .intr_req_i(intr_req_i), .rd_data_q(rd_data_q), .flags_q(flags_q),
    .msw_q(msw_q), .ip_q(ip_q), .ea_off_q(ea_off_q), .phys_addr_q(phys_addr_q),
    .addr_valid_q(addr_valid_q), .mem_wr_q(mem_wr_q), .mem_wdata_q(mem_wdata_q),
    .trap_take_q(trap_take_q), .intr_take_q(intr_take_q), .op_bad_q(op_bad_q));

  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // One operation, taken at the next rising edge
  task automatic do_op(input crsf_alu_op_t f, input logic w, input crsf_src_t s, input crsf_dst_t d,
                       input logic [2:0] di, input logic dh, input logic [15:0] im, input logic [1:0] n);
    crsf_op_t o;
    o = '0;
    o.valid = 1'b1; o.nops = n; o.alu_op = f; o.word = w; o.src = s; o.dst = d;
    o.dst_idx = di; o.dst_hi = dh; o.imm = im; o.mem_src = im; o.mem_dst = 16'h0100;
    @(negedge clk) op_i = o;
    @(negedge clk) op_i = '0;
  endtask : do_op

  task automatic fcmd(input crsf_flag_cmd_t c, input logic [15:0] v);
    @(negedge clk) begin flag_cmd_i = c; flag_load_i = v; end
    @(negedge clk) flag_cmd_i = FC_NONE;
  endtask : fcmd

  task automatic rd(input logic [2:0] i, input logic w, input logic h);
    @(negedge clk) begin rd_idx_i = i; rd_word_i = w; rd_hi_i = h; end
    @(negedge clk);
  endtask : rd

  task automatic ea_go(input crsf_amode_t m, input logic bp, input logic db, input logic [15:0] dp);
    crsf_ea_t e;
    e = '0;
    e.valid = 1'b1; e.mode = m; e.base_bp = bp; e.disp_byte = db; e.disp = dp;
    @(negedge clk) ea_i = e;
    @(negedge clk) ea_i = '0;
  endtask : ea_go

  task automatic done_pulse;
    @(negedge clk) insn_done_i = 1'b1;
    @(negedge clk) insn_done_i = 1'b0;
  endtask : done_pulse

  task automatic test_alu;
    `CHK("reset flags", 16'h0000, flags_q)
    do_op(ALU_ADD, 1'b1, SRC_IMM, DST_REG, R_ACC, 1'b0, 16'h7fff, 2'h2);
    do_op(ALU_ADD, 1'b1, SRC_IMM, DST_REG, R_ACC, 1'b0, 16'h0001, 2'h2);
    `CHK("add ovf flags", 16'h0894, flags_q)
    rd(R_ACC, 1'b1, 1'b0);
    `CHK("acc word", 16'h8000, rd_data_q)
    do_op(ALU_MOV, 1'b0, SRC_IMM, DST_REG, R_ACC, 1'b1, 16'h0012, 2'h2);
    rd(R_ACC, 1'b0, 1'b1);
    `CHK("acc high byte", 16'h0012, rd_data_q)
    `CHK("mov keeps flags", 16'h0894, flags_q)
    do_op(ALU_ADD, 1'b1, SRC_REG, DST_MEM, R_ACC, 1'b0, 16'h0000, 2'h2);
    `CHK("mem write", 1'b1, mem_wr_q)
    `CHK("mem data", 16'h1300, mem_wdata_q)
    do_op(ALU_SUB, 1'b1, SRC_IMM, DST_REG, R_CNT, 1'b0, 16'h0001, 2'h2);
    `CHK("borrow flags", 16'h0095, flags_q)
    do_op(ALU_ADD, 1'b1, SRC_IMM, DST_REG, R_CNT, 1'b0, 16'h0001, 2'h2);
    `CHK("zero flags", 16'h0055, flags_q)
    do_op(ALU_ADD, 1'b0, SRC_IMM, DST_REG, 3'h4, 1'b1, 16'h0001, 2'h2);
    `CHK("bad high byte", 1'b1, op_bad_q)
    do_op(ALU_ADD, 1'b1, SRC_IMM, DST_REG, R_ACC, 1'b0, 16'h0001, 2'h3);
    `CHK("bad count", 1'b1, op_bad_q)
    `CHK("refused flags", 16'h0055, flags_q)
    $display("test alu done");
  endtask : test_alu

  task automatic test_ctrl;
    fcmd(FC_LOAD, 16'hffff);
    `CHK("load flags", 16'h0fd5, flags_q)
    done_pulse();
    `CHK("trap taken", 1'b1, trap_take_q)
    `CHK("trap clears", 16'h0cd5, flags_q)
    intr_req_i = 1'b1;
    fcmd(FC_STI, 16'h0000);
    repeat (3) @(negedge clk);
    done_pulse();
    `CHK("intr taken", 1'b1, intr_take_q)
    `CHK("intr clears", 16'h0cd5, flags_q)
    done_pulse();
    `CHK("intr masked", 1'b0, intr_take_q)
    intr_req_i = 1'b0;
    fcmd(FC_CLC, 16'h0000);
    `CHK("clc", 16'h0cd4, flags_q)
    fcmd(FC_STC, 16'h0000);
    `CHK("stc", 16'h0cd5, flags_q)
    fcmd(FC_CMC, 16'h0000);
    `CHK("cmc", 16'h0cd4, flags_q)
    @(negedge clk) begin str_step_i = 1'b1; str_word_i = 1'b1; end
    @(negedge clk) str_step_i = 1'b0;
    rd(R_SRCI, 1'b1, 1'b0);
    `CHK("index down", 16'hfffe, rd_data_q)
    fcmd(FC_CLD, 16'h0000);
    @(negedge clk) begin str_step_i = 1'b1; str_word_i = 1'b0; end
    @(negedge clk) str_step_i = 1'b0;
    rd(R_DSTI, 1'b1, 1'b0);
    `CHK("index up", 16'hffff, rd_data_q)
    fcmd(FC_STD, 16'h0000);
    `CHK("std", 16'h0cd4, flags_q)
    $display("test ctrl done");
  endtask : test_ctrl

  task automatic test_addr;
    @(negedge clk) begin seg_wr_i = 1'b1; seg_idx_i = S_DATA; seg_data_i = 16'h1234; end
    @(negedge clk) seg_wr_i = 1'b0;
    ea_go(AM_DIRECT, 1'b0, 1'b0, 16'h0010);
    `CHK("ea valid", 1'b1, addr_valid_q)
    `CHK("real phys", 24'h012350, phys_addr_q)
    ea_go(AM_BASED, 1'b1, 1'b1, 16'h00f0);
    `CHK("based off", 16'hfff0, ea_off_q)
    `CHK("stack phys", 24'h00fff0, phys_addr_q)
    @(negedge clk) begin msw_wr_i = 1'b1; msw_data_i = 16'h0001; seg_base_i = 24'h100000; end
    @(negedge clk) msw_wr_i = 1'b0;
    `CHK("msw", 16'h0001, msw_q)
    ea_go(AM_DIRECT, 1'b0, 1'b0, 16'h0010);
    `CHK("prot phys", 24'h100010, phys_addr_q)
    @(negedge clk) begin ip_load_i = 1'b1; ip_data_i = 16'h0100; end
    @(negedge clk) begin ip_load_i = 1'b0; ip_adv_i = 4'h2; end
    repeat (3) @(negedge clk);
    ip_adv_i = 4'h0;
    `CHK("ip advance", 16'h0106, ip_q)
    repeat (20) @(negedge clk);
    `CHK("idle hold", 16'h0106, ip_q)
    `CHK("flags hold", 16'h0cd4, flags_q)
    $display("test addr done");
  endtask : test_addr

  // Further operations (INC, ADC, CMP, SBB, AND, NEG, NOT), flag commands, two offset modes and a second reset
  task automatic test_more;
    fcmd(FC_STC, 16'h0000);
    do_op(ALU_INC, 1'b1, SRC_IMM, DST_REG, R_CNT, 1'b0, 16'h0000, 2'h1);
    `CHK("inc keeps carry", 16'h0401, flags_q)
    do_op(ALU_ADC, 1'b1, SRC_MEM, DST_REG, R_CNT, 1'b0, 16'h00ff, 2'h2);
    `CHK("adc flags", 16'h0410, flags_q)
    do_op(ALU_CMP, 1'b1, SRC_IMM, DST_REG, R_CNT, 1'b0, 16'h0101, 2'h2);
    `CHK("cmp flags", 16'h0444, flags_q)
    rd(R_CNT, 1'b1, 1'b0);
    `CHK("cmp keeps reg", 16'h0101, rd_data_q)
    do_op(ALU_SBB, 1'b0, SRC_IMM, DST_REG, R_CNT, 1'b1, 16'h0002, 2'h2);
    `CHK("sbb flags", 16'h0495, flags_q)
    rd(R_CNT, 1'b1, 1'b0);
    `CHK("sbb high byte", 16'hff01, rd_data_q)
    do_op(ALU_AND, 1'b1, SRC_IMM, DST_REG, R_CNT, 1'b0, 16'h0f0f, 2'h2);
    `CHK("and flags", 16'h0400, flags_q)
    do_op(ALU_NEG, 1'b1, SRC_IMM, DST_REG, R_CNT, 1'b0, 16'h0000, 2'h1);
    `CHK("neg flags", 16'h0495, flags_q)
    do_op(ALU_NOT, 1'b1, SRC_IMM, DST_REG, R_CNT, 1'b0, 16'h0000, 2'h1);
    do_op(ALU_ADD, 1'b1, SRC_IMM, DST_REG, R_CNT, 1'b0, 16'h0001, 2'h0);
    rd(R_CNT, 1'b1, 1'b0);
    `CHK("not then no operand", 16'h0f00, rd_data_q)
    fcmd(FC_STI, 16'h0000);
    `CHK("sti", 16'h0695, flags_q)
    fcmd(FC_CLI, 16'h0000);
    `CHK("cli", 16'h0495, flags_q)
    ea_go(AM_INDEXED, 1'b0, 1'b0, 16'h0003);
    `CHK("indexed off", 16'h0002, ea_off_q)
    ea_go(AM_BIDX_DISP, 1'b0, 1'b1, 16'h0080);
    `CHK("based indexed off", 16'hff7f, ea_off_q)
    @(negedge clk) rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    `CHK("reset again flags", 16'h0000, flags_q)
    `CHK("reset again msw", 16'h0000, msw_q)
    $display("test more done");
  endtask : test_more

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  initial begin
    {rst_n, seg_wr_i, msw_wr_i, ip_load_i, insn_done_i, str_step_i, str_word_i, intr_req_i} = '0;
    {rd_word_i, rd_hi_i, flag_load_i, seg_data_i, msw_data_i, ip_data_i, seg_base_i} = '0;
    {rd_idx_i, seg_idx_i, ip_adv_i} = '0;
    op_i = '0; ea_i = '0; flag_cmd_i = FC_NONE;
    mismatches = 0; cmp_count = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    test_alu();
    test_ctrl();
    test_addr();
    test_more();
    complete_run();
  end
endmodule : testbench
